// ---- core/pclk_map.svh ----
`ifndef PCLK_MAP_SVH
`define PCLK_MAP_SVH
`define PCLK_ADDR_SRC 8'h00
`define PCLK_ADDR_ENDIV 8'h04
`define PCLK_ADDR_PIN 8'h08
`define PCLK_ADDR_STAT 8'h0c
`define PCLK_SRC_MASK 8'h03
`define PCLK_ENDIV_MASK 8'h87
`define PCLK_PIN_MASK 8'h01
`define PCLK_REG_RST 8'h00
`define PCLK_EN_BIT 7
`define PCLK_DIV_HI 2
`define PCLK_DIV_LO 0
`define PCLK_SRC_HI 1
`define PCLK_SRC_LO 0
`define PCLK_SYS4_LAST 2'h3
`define PCLK_RESP_OKAY 2'h0
`define PCLK_RESP_SLVERR 2'h2
`endif

// ---- core/pclk_pkg.sv ----
package pclk_pkg;
  typedef enum logic [1:0] {
    PCLK_SRC_SYS = 2'h0,
    PCLK_SRC_SYS4 = 2'h1,
    PCLK_SRC_TB = 2'h2,
    PCLK_SRC_HS = 2'h3
  } pclk_src_t;

  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } pclk_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } pclk_axi_rsp_t;

  typedef struct packed {
    logic o;
    logic oe;
  } pclk_pin_t;
endpackage

// ---- core/pclk_sync.sv ----
`timescale 1ns/1ns
`default_nettype none
module pclk_sync #(
  parameter int W = 1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] meta_next;
  logic [W-1:0] q_next;

  // first stage feeds only the second stage
  always_comb begin
    meta_next = d;
    q_next = meta_reg;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_reg <= '0;
      q <= '0;
    end else begin
      meta_reg <= meta_next;
      q <= q_next;
    end
  end
endmodule
`default_nettype wire

// ---- core/pclk_out_ctrl.sv ----
// What this block does
// R1: output clock made from, aligned to, internal clock
// R2: source select 00 sys,01 sys/4,10 timebase,11 oscillator
// R3: divider field n toggles the output every 2**n ticks of the base clock
// R4: output runs only while enable bit is 1
// R5: stopped source in power-down stops the output
// R6: pin carries clock only when pin-share selects it
// R7: unimplemented register bits read as zero
// R8: disabled means counter cleared, output held low
`timescale 1ns/1ns
`default_nettype none
`include "pclk_map.svh"
module pclk_out_ctrl (
  input wire logic aclk,
  input wire logic aresetn,
  input wire pclk_pkg::pclk_axi_req_t axi_req,
  output pclk_pkg::pclk_axi_rsp_t axi_rsp,
  input wire logic time_base_clock,
  input wire logic high_speed_osc_clock,
  input wire logic [3:0] src_off,
  input wire pclk_pkg::pclk_pin_t gpio_drive,
  output pclk_pkg::pclk_pin_t periph_clk_out
);
  // ---------------- register bus ----------------
  pclk_pkg::pclk_axi_rsp_t rsp_next;
  logic [7:0] src_reg, src_next;
  logic [7:0] endiv_reg, endiv_next;
  logic [7:0] pin_reg, pin_next;
  logic aw_full_reg, aw_full_next;
  logic w_full_reg, w_full_next;
  logic [7:0] awaddr_reg, awaddr_next;
  logic [31:0] wdata_reg, wdata_next;
  logic wstrb0_reg, wstrb0_next;
  logic out_reg, out_next;
  logic run_reg, run_next;
  logic [6:0] cnt_reg, cnt_next;

  logic aw_take, w_take, aw_have, w_have, wr_lane;
  logic [7:0] wr_addr;
  logic [7:0] wr_byte;

  always_comb begin
    rsp_next = axi_rsp;
    src_next = src_reg;
    endiv_next = endiv_reg;
    pin_next = pin_reg;
    aw_full_next = aw_full_reg;
    w_full_next = w_full_reg;
    awaddr_next = awaddr_reg;
    wdata_next = wdata_reg;
    wstrb0_next = wstrb0_reg;
    aw_take = axi_req.awvalid && axi_rsp.awready;
    w_take = axi_req.wvalid && axi_rsp.wready;
    aw_have = aw_full_reg || aw_take;
    w_have = w_full_reg || w_take;
    wr_addr = aw_full_reg ? awaddr_reg : axi_req.awaddr;
    wr_byte = w_full_reg ? wdata_reg[7:0] : axi_req.wdata[7:0];
    wr_lane = w_full_reg ? wstrb0_reg : axi_req.wstrb[0];
    if (axi_rsp.bvalid && axi_req.bready) begin
      rsp_next.bvalid = 1'b0;
    end
    if (aw_take) begin
      aw_full_next = 1'b1;
      awaddr_next = axi_req.awaddr;
    end
    if (w_take) begin
      w_full_next = 1'b1;
      wdata_next = axi_req.wdata;
      wstrb0_next = axi_req.wstrb[0];
    end
    if (aw_have && w_have && !axi_rsp.bvalid) begin
      aw_full_next = 1'b0;
      w_full_next = 1'b0;
      rsp_next.bvalid = 1'b1;
      rsp_next.bresp = `PCLK_RESP_OKAY;
      // masking on write keeps the unimplemented bits at zero
      case (wr_addr)
        `PCLK_ADDR_SRC: begin
          if (wr_lane) src_next = wr_byte & `PCLK_SRC_MASK; // R7
        end
        `PCLK_ADDR_ENDIV: begin
          if (wr_lane) endiv_next = wr_byte & `PCLK_ENDIV_MASK; // R7
        end
        `PCLK_ADDR_PIN: begin
          if (wr_lane) pin_next = wr_byte & `PCLK_PIN_MASK;
        end
        `PCLK_ADDR_STAT: begin
          rsp_next.bresp = `PCLK_RESP_OKAY;
        end
        default: begin
          rsp_next.bresp = `PCLK_RESP_SLVERR;
        end
      endcase
    end
    rsp_next.awready = !aw_full_next && !rsp_next.bvalid;
    rsp_next.wready = !w_full_next && !rsp_next.bvalid;
    if (axi_rsp.rvalid && axi_req.rready) begin
      rsp_next.rvalid = 1'b0;
    end
    if (axi_req.arvalid && axi_rsp.arready) begin
      rsp_next.rvalid = 1'b1;
      rsp_next.rresp = `PCLK_RESP_OKAY;
      rsp_next.rdata = '0;
      case (axi_req.araddr)
        `PCLK_ADDR_SRC: rsp_next.rdata[7:0] = src_reg;
        `PCLK_ADDR_ENDIV: rsp_next.rdata[7:0] = endiv_reg;
        `PCLK_ADDR_PIN: rsp_next.rdata[7:0] = pin_reg;
        `PCLK_ADDR_STAT: rsp_next.rdata[7:0] = {6'h00, run_reg, out_reg};
        default: rsp_next.rresp = `PCLK_RESP_SLVERR;
      endcase
    end
    rsp_next.arready = !rsp_next.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      axi_rsp <= '0;
      src_reg <= `PCLK_REG_RST;
      endiv_reg <= `PCLK_REG_RST;
      pin_reg <= `PCLK_REG_RST;
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= '0;
      wstrb0_reg <= 1'b0;
    end else begin
      axi_rsp <= rsp_next;
      src_reg <= src_next;
      endiv_reg <= endiv_next;
      pin_reg <= pin_next;
      aw_full_reg <= aw_full_next;
      w_full_reg <= w_full_next;
      awaddr_reg <= awaddr_next;
      wdata_reg <= wdata_next;
      wstrb0_reg <= wstrb0_next;
    end
  end

  // ---------------- clock generation ----------------
  // external clocks and power-down flags come from other domains
  logic [5:0] sync_q;
  pclk_sync #(.W(6)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d({src_off, high_speed_osc_clock, time_base_clock}),
    .q(sync_q)
  );

  pclk_pkg::pclk_src_t src_sel;
  pclk_pkg::pclk_pin_t pin_next_v;
  logic [1:0] pre_reg, pre_next;
  logic tb_d_reg, tb_d_next, hs_d_reg, hs_d_next;
  logic tick, en_bit, src_stopped;
  logic [2:0] div_sel;
  logic [6:0] lim;

  always_comb begin
    src_sel = pclk_pkg::pclk_src_t'(src_reg[`PCLK_SRC_HI:`PCLK_SRC_LO]);
    div_sel = endiv_reg[`PCLK_DIV_HI:`PCLK_DIV_LO];
    en_bit = endiv_reg[`PCLK_EN_BIT];
    // each tick is one edge of the base clock, so div 0 toggles per tick
    lim = (7'h01 << div_sel) - 7'h01; // R3
    pre_next = pre_reg + 2'h1;
    tb_d_next = sync_q[0];
    hs_d_next = sync_q[1];
    src_stopped = sync_q[2 + src_sel]; // R5
    case (src_sel) // R2
      pclk_pkg::PCLK_SRC_SYS: tick = 1'b1;
      pclk_pkg::PCLK_SRC_SYS4: tick = (pre_reg == `PCLK_SYS4_LAST);
      pclk_pkg::PCLK_SRC_TB: tick = sync_q[0] ^ tb_d_reg;
      pclk_pkg::PCLK_SRC_HS: tick = sync_q[1] ^ hs_d_reg;
      default: tick = 1'b0;
    endcase
    run_next = en_bit && !src_stopped; // R4 R5
    cnt_next = cnt_reg;
    out_next = out_reg;
    if (!run_next) begin
      cnt_next = 7'h00; // R8
      out_next = 1'b0; // R8
    end else if (tick) begin // R1
      if (cnt_reg >= lim) begin
        cnt_next = 7'h00;
        out_next = !out_reg;
      end else begin
        cnt_next = cnt_reg + 7'h01;
      end
    end
    // pin stays a plain gpio unless routed to the clock
    if (pin_reg[0]) begin // R6
      pin_next_v.o = out_reg;
      pin_next_v.oe = 1'b1;
    end else begin
      pin_next_v = gpio_drive;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre_reg <= 2'h0;
      tb_d_reg <= 1'b0;
      hs_d_reg <= 1'b0;
      run_reg <= 1'b0;
      cnt_reg <= 7'h00;
      out_reg <= 1'b0;
      periph_clk_out <= '0;
    end else begin
      pre_reg <= pre_next;
      tb_d_reg <= tb_d_next;
      hs_d_reg <= hs_d_next;
      run_reg <= run_next;
      cnt_reg <= cnt_next;
      out_reg <= out_next;
      periph_clk_out <= pin_next_v;
    end
  end

  // ---------------- checks ----------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  toggle_at_wrap_a: assert property (run_next && tick && cnt_reg >= lim |=> out_reg != $past(out_reg)) // R1
    else $error("output did not toggle at divider wrap");
  count_step_a: assert property (run_next && tick && cnt_reg < lim |=> cnt_reg == 7'($past(cnt_reg) + 7'h01)) // R3
    else $error("divider count did not advance");
  sys_tick_a: assert property (src_sel == pclk_pkg::PCLK_SRC_SYS |-> tick) // R2
    else $error("system clock source not ticking each cycle");
  // a source switch right after a prescaler tick may tick at once, so only sys/4 ticks count here
  sys4_tick_a: assert property (src_sel == pclk_pkg::PCLK_SRC_SYS4 && tick |=> // R2
    (src_sel != pclk_pkg::PCLK_SRC_SYS4 || !tick) [*3])
    else $error("divided system clock ticks too often");
  disabled_low_a: assert property (!en_bit |=> !out_reg && cnt_reg == 7'h00) // R4
    else $error("output active while disabled");
  // the first tick may toggle in the very cycle run starts, so look at the state it started from
  clean_start_a: assert property ($rose(run_reg) |-> $past(out_reg) == 1'b0 && $past(cnt_reg) == 7'h00) // R8
    else $error("enable did not start from a clean state");
  power_stop_a: assert property (src_stopped |=> !out_reg ##1 !periph_clk_out.o || !pin_reg[0]) // R5
    else $error("output still running with source stopped");
  pin_route_a: assert property (pin_reg[0] |=> periph_clk_out.oe && periph_clk_out.o == $past(out_reg)) // R6
    else $error("clock not routed to pin");
  gpio_keep_a: assert property (!pin_reg[0] |=> periph_clk_out == $past(gpio_drive)) // R6
    else $error("pin lost its gpio role");
  reserved_zero_a: assert property (src_reg[7:2] == 6'h00 && endiv_reg[6:3] == 4'h0) // R7
    else $error("unimplemented bits not zero");
  rdata_hold_a: assert property (axi_rsp.rvalid && !axi_req.rready |=> axi_rsp.rvalid && $stable(axi_rsp.rdata))
    else $error("read data dropped before accept");

  toggle_c: cover property (run_reg && out_reg ##1 !out_reg);
  div128_c: cover property (run_reg && div_sel == 3'h7 && cnt_reg == 7'h7f);
  pwr_stop_c: cover property (run_reg ##1 src_stopped);
  slverr_c: cover property (axi_rsp.rvalid && axi_rsp.rresp == `PCLK_RESP_SLVERR);
endmodule
`default_nettype wire

// ---- bench/pclk_ext_sink.sv ----
`timescale 1ns/1ns
`default_nettype none
module pclk_ext_sink (
  input wire pclk_pkg::pclk_pin_t pin,
  output int period_ns,
  output int edges
);
  logic lvl;
  time last;
  // released pin falls to the board pull-down, never the last value
  assign lvl = pin.oe ? pin.o : 1'b0;
  initial begin
    period_ns = 0;
    edges = 0;
    last = 0;
  end
  // the sink is clocked by the pin alone and just times its rising edges
  always @(posedge lvl) begin
    if (last != 0) period_ns = int'($time - last);
    last = $time;
    edges = edges + 1;
  end
endmodule
`default_nettype wire

// ---- bench/tb.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "pclk_map.svh"
module tb;
  logic aclk, aresetn, tbc, hsc;
  logic [3:0] src_off;
  pclk_pkg::pclk_axi_req_t req;
  pclk_pkg::pclk_axi_rsp_t rsp;
  pclk_pkg::pclk_pin_t gpio_drive, pin;
  int bad_count, n_compared, per, edges, k, cyc_n, n;
  int ticks[4] = '{1, 4, 5, 3};
  // register model: implemented bits only, unimplemented ones read as zero
  int mdl[3] = '{32'h0, 32'h0, 32'h0};
  int msk[3] = '{32'h3, 32'h87, 32'h1};
  logic [31:0] d, q;
  logic [1:0] r;
  pclk_out_ctrl dut (.aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp), .time_base_clock(tbc),
    .high_speed_osc_clock(hsc), .src_off(src_off), .gpio_drive(gpio_drive), .periph_clk_out(pin));
  pclk_ext_sink sink (.pin(pin), .period_ns(per), .edges(edges));
  initial begin
    aclk = 0;
    forever #2 aclk = ~aclk;
  end
  // slow sources derived from aclk: a tick every 5 and every 3 cycles
  always @(posedge aclk) begin
    k <= k + 1;
    if (k % 5 == 4) tbc <= ~tbc;
    if (k % 3 == 2) hsc <= ~hsc;
    cyc_n <= cyc_n + 1;
    if (cyc_n == 60000) begin
      bad_count = bad_count + 1;
      summarize();
    end
  end
  task automatic summarize();
    if (bad_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared = n_compared + 1;
    if (seen !== exp) begin
      bad_count = bad_count + 1;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge aclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    bit aw, w;
    aw = 0;
    w = 0;
    req.awaddr <= a;
    req.wdata <= v;
    req.wstrb <= 4'hf;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (req.awvalid && rsp.awready) begin
        aw = 1;
        req.awvalid <= 1'b0;
      end
      if (req.wvalid && rsp.wready) begin
        w = 1;
        req.wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (rsp.bvalid !== 1'b1);
    rs = rsp.bresp;
    // bready stays up: lowering it here would clash with the next call raising it
    if (rs == `PCLK_RESP_OKAY && a < `PCLK_ADDR_STAT) mdl[a >> 2] = v & msk[a >> 2];
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    do @(posedge aclk); while (rsp.arready !== 1'b1);
    req.arvalid <= 1'b0;
    do @(posedge aclk); while (rsp.rvalid !== 1'b1);
    v = rsp.rdata;
    rs = rsp.rresp;
  endtask
  initial begin
    req = '0;
    src_off = 4'h0;
    gpio_drive = '0;
    tbc = 0;
    hsc = 0;
    k = 0;
    cyc_n = 0;
    bad_count = 0;
    n_compared = 0;
    aresetn = 0;
    d = $urandom(99492);
    // sync flops in the block reset directly, so one edge of reset clears both stages
    cyc(3);
    aresetn <= 1'b1;
    cyc(2);
    rd(`PCLK_ADDR_SRC, q, r);
    chk(q, 32'h0);
    rd(`PCLK_ADDR_ENDIV, q, r);
    chk(q, 32'h0);
    gpio_drive <= 2'($urandom);
    cyc(3);
    chk(pin, gpio_drive);
    d = $urandom;
    wr(`PCLK_ADDR_SRC, d, r);
    rd(`PCLK_ADDR_SRC, q, r);
    chk(q, mdl[0]);
    wr(`PCLK_ADDR_ENDIV, d & 32'hffff_ff7f, r);
    rd(`PCLK_ADDR_ENDIV, q, r);
    chk(q, mdl[1]);
    wr(8'h10, d, r);
    chk(r, 2'h2);
    rd(8'h10, q, r);
    chk(r, 2'h2);
    wr(`PCLK_ADDR_PIN, 32'h1, r);
    rd(`PCLK_ADDR_PIN, q, r);
    chk(q, mdl[2]);
    for (int s = 0; s < 4; s++) begin
      for (int v = 0; v < 8; v++) begin
        wr(`PCLK_ADDR_SRC, ($urandom & 32'hfc) | s, r);
        wr(`PCLK_ADDR_ENDIV, 32'h80 | v, r);
        n = 2 * ticks[s] * (1 << v);
        cyc(3 * n + 40);
        // pin edges land on aclk edges, so ns period is exact
        chk(per, n * 4);
      end
    end
    wr(`PCLK_ADDR_ENDIV, 32'h0, r);
    cyc(6);
    n = edges;
    cyc(50);
    chk(edges, n);
    chk(pin.o, 1'b0);
    wr(`PCLK_ADDR_SRC, 32'h1, r);
    wr(`PCLK_ADDR_ENDIV, 32'h80, r);
    src_off <= 4'b1101;
    n = edges;
    cyc(60);
    chk(edges > n, 1'b1);
    chk(pin.oe, 1'b1);
    rd(`PCLK_ADDR_STAT, q, r);
    chk(q[1], 1'b1);
    src_off <= 4'b0010;
    cyc(10);
    n = edges;
    cyc(50);
    chk(edges, n);
    chk(pin.o, 1'b0);
    rd(`PCLK_ADDR_STAT, q, r);
    chk(q, 32'h0);
    summarize();
  end
endmodule
`default_nettype wire
